// ==== csq_params.svh ====
// csq_params.svh: timing counts and rest levels for the split-frame sensor clock sequencer.
// assumes a 125 MHz system clock; times are kept in ns and turned into cycle counts here.
`ifndef CSQ_PARAMS_SVH
`define CSQ_PARAMS_SVH

// system clock period
`define CSQ_CLK_NS 8
// serial stop to first image rise, typical figure (least time: round up)
`define CSQ_T_DRT_NS 10000
`define CSQ_DRT_CYC ((`CSQ_T_DRT_NS + `CSQ_CLK_NS - 1) / `CSQ_CLK_NS)
// image_edge_overlap, typical figure (longest time: round down)
`define CSQ_T_OI_NS 10000
`define CSQ_OI_CYC (`CSQ_T_OI_NS / `CSQ_CLK_NS)
// last image fall to serial restart (least time: round up)
`define CSQ_T_DTR_NS 10000
`define CSQ_DTR_CYC ((`CSQ_T_DTR_NS + `CSQ_CLK_NS - 1) / `CSQ_CLK_NS)
// serial period (least time: round up)
`define CSQ_T_SER_NS 1000
`define CSQ_SER_CYC ((`CSQ_T_SER_NS + `CSQ_CLK_NS - 1) / `CSQ_CLK_NS)
// serial phase overlap (longest time: round down)
`define CSQ_T_OR_NS 50
`define CSQ_OR_CYC (`CSQ_T_OR_NS / `CSQ_CLK_NS)
// reset_pulse_width (longest time: round down)
`define CSQ_T_WX_NS 60
`define CSQ_WX_CYC (`CSQ_T_WX_NS / `CSQ_CLK_NS)
// reset_to_phase2_delay (least time: round up)
`define CSQ_T_DX_NS 30
`define CSQ_DX_CYC ((`CSQ_T_DX_NS + `CSQ_CLK_NS - 1) / `CSQ_CLK_NS)
// phase 2/3 fall to dump gate fall, and dump gate fall to phase 2/3 rise
`define CSQ_T_DUMP_NS 20000
`define CSQ_DUMP_CYC ((`CSQ_T_DUMP_NS + `CSQ_CLK_NS - 1) / `CSQ_CLK_NS)
// image drive rest pattern while charge collects: drives 1 and 2 high
`define CSQ_IMG_REST 4'h3

`endif

// ==== csq_pkg.sv ====
// csq_pkg.sv: types shared by the sensor clock sequencer.
// assumes csq_params.svh supplies all numeric constants.
package csq_pkg;

  // readout routing selected before a frame
  typedef enum logic [1:0] {
    CSQ_SPLIT = 2'b00,      // each section toward its own register
    CSQ_FULL_LOWER = 2'b01, // whole frame into the lower register
    CSQ_FULL_UPPER = 2'b10  // whole frame into the upper register
  } csq_mode_e;

  // sequencer states
  typedef enum logic [2:0] {
    CSQ_IDLE = 3'b000, // clocks static, collecting charge
    CSQ_PRE = 3'b001,  // serial stopped, waiting before first image edge
    CSQ_IMG = 3'b010,  // image edge sequence
    CSQ_POST = 3'b011, // wait after last image edge
    CSQ_SER = 3'b100,  // serial readout of one line
    CSQ_DHOLD = 3'b101, // dump gate at dumping level
    CSQ_DREST = 3'b110  // dump gate back, phases 2/3 held low
  } csq_state_e;

  // frame configuration; halves: 0 upper left, 1 upper right, 2 lower left, 3 lower right
  typedef struct packed {
    csq_mode_e mode;
    logic [3:0] reverse;    // half shifts toward the opposite output
    logic [3:0] sum_enable; // summing well gate used for summing
    logic [3:0] sum_count;  // pixels summed per packet (0 acts as 1)
  } csq_cfg_s;

  // sensor drive pins; image phase bit n is phase n+1
  typedef struct packed {
    logic [3:0] upper_image_phase;
    logic [3:0] lower_image_phase;
    logic upper_transfer_gate;
    logic lower_transfer_gate;
    logic upper_register_phase_1;
    logic lower_register_phase_1;
    logic upper_left_phase_2;
    logic upper_left_phase_3;
    logic upper_right_phase_2;
    logic upper_right_phase_3;
    logic lower_left_phase_2;
    logic lower_left_phase_3;
    logic lower_right_phase_2;
    logic lower_right_phase_3;
    logic upper_left_summing_gate;
    logic upper_right_summing_gate;
    logic lower_left_summing_gate;
    logic lower_right_summing_gate;
    logic [3:0] output_reset; // one per output, same order as halves
    logic [1:0] charge_dump_gate; // 0 upper register, 1 lower register
  } csq_pins_s;

endpackage : csq_pkg

// ==== csq_sensor_model.sv ====
// csq_sensor_model.sv: behavioural split-frame sensor watching its clock pins.
// assumes pins are registered on i_clk, so one sample a cycle sees every edge.
`timescale 1ns/1ps
module csq_sensor_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire csq_pkg::csq_pins_s i_pins,
  output logic [15:0] o_gate_falls, // lines handed over to a register
  output logic o_fault              // sticky: image moved with a phase 2 low
);
  csq_pkg::csq_pins_s prev_r; // pins one cycle ago
  logic p2_all; // charge only enters beneath phase 2, so all must be high
  assign p2_all = i_pins.upper_left_phase_2 & i_pins.upper_right_phase_2 &
    i_pins.lower_left_phase_2 & i_pins.lower_right_phase_2;
  // a gate fall drops one line into its register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_r <= '0;
      o_gate_falls <= 16'h0000;
      o_fault <= 1'b0;
    end else begin
      prev_r <= i_pins;
      o_gate_falls <= o_gate_falls + 16'(prev_r.upper_transfer_gate & ~i_pins.upper_transfer_gate)
        + 16'(prev_r.lower_transfer_gate & ~i_pins.lower_transfer_gate);
      if ({i_pins.upper_image_phase, i_pins.lower_image_phase} !==
          {prev_r.upper_image_phase, prev_r.lower_image_phase} && !p2_all) begin
        o_fault <= 1'b1;
      end
    end
  end
endmodule : csq_sensor_model

// ==== csq_sequencer.sv ====
// csq_sequencer.sv: clock generator that drives a split-frame image sensor's clock pins.
// assumes a 125 MHz clock, pins buffered to analog drivers, and config held stable at start.
`timescale 1ns/1ps
`include "csq_params.svh"

module csq_sequencer #(
  parameter int LINE_W = 13, // line counter width (2 x 2068 rows fit)
  parameter int PIX_W = 13   // pixel counter width
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,                    // pulse: begin reading one frame
  input wire csq_pkg::csq_cfg_s i_cfg,         // latched with i_start
  input wire logic [LINE_W-1:0] i_line_count,  // lines to read (0 acts as 1)
  input wire logic [LINE_W-1:0] i_dump_lines,  // leading lines discarded
  input wire logic [PIX_W-1:0] i_pixel_count,  // serial cycles per line (0 acts as 1)
  output csq_pkg::csq_pins_s o_pins,           // registered sensor drive pins
  output logic o_busy,                         // level: frame in progress
  output logic o_pixel_valid,                  // pulse: a packet reached its output
  output logic o_frame_done                    // pulse: frame finished
);

  // timer counts as 12-bit values; all stay below 4096
  localparam logic [11:0] DRT = 12'(`CSQ_DRT_CYC);
  localparam logic [11:0] OI = 12'(`CSQ_OI_CYC);
  localparam logic [11:0] DTR = 12'(`CSQ_DTR_CYC);
  localparam logic [11:0] SER = 12'(`CSQ_SER_CYC);
  localparam logic [11:0] OVL = 12'(`CSQ_OR_CYC);
  localparam logic [11:0] WX = 12'(`CSQ_WX_CYC);
  localparam logic [11:0] DX = 12'(`CSQ_DX_CYC);
  localparam logic [11:0] DUMP = 12'(`CSQ_DUMP_CYC);
  // serial edge positions within one pixel; phase 2 kept short on purpose
  localparam logic [11:0] T2F = WX + DX;   // phase 2 falls
  localparam logic [11:0] T3F = SER >> 1;  // phase 3 falls mid-pixel

  // refuse widths, a dump count the timer cannot serve, and edge positions the pixel cycle cannot fit, at elaboration
  if (LINE_W < 1 || LINE_W > 16 || PIX_W < 1 || PIX_W > 16) begin : g_bad_width
    $error("csq_sequencer: counter widths must be 1..16");
  end
  if (`CSQ_DUMP_CYC > 4095 || T3F <= T2F || T2F <= OVL) begin : g_bad_timing
    $error("csq_sequencer: timing counts do not fit the pixel cycle");
  end

  csq_pkg::csq_state_e state_r; // sequencer state
  csq_pkg::csq_cfg_s cfg_r;     // frame configuration, fixed during a frame
  logic [11:0] tmr_r;           // down counter for long waits
  logic [11:0] pc_r;            // position inside one serial period
  logic [2:0] step_r;           // image edge step, 0 is rest pattern
  logic [LINE_W-1:0] line_r;    // current line
  logic [PIX_W-1:0] pix_r;      // current pixel in line
  logic [3:0] sum_r;            // pixels gathered in summing wells
  logic [LINE_W-1:0] last_line; // last line index
  logic [PIX_W-1:0] last_pix;   // last pixel index
  logic pix_end;                // end of a serial period
  logic line_end;               // last pixel of last serial period
  logic sum_last;               // this pixel releases summed charge
  csq_pkg::csq_pins_s pins_nxt; // next pin values

  // image drive pattern per step: each step moves exactly one edge
  function automatic logic [3:0] img_pattern(input logic [2:0] step);
    case (step)
      3'h0: img_pattern = `CSQ_IMG_REST; // 1,2 high
      3'h1: img_pattern = 4'h7;          // 3 rises
      3'h2: img_pattern = 4'h6;          // 1 falls
      3'h3: img_pattern = 4'he;          // 4 rises
      3'h4: img_pattern = 4'hc;          // 2 falls
      3'h5: img_pattern = 4'hd;          // 1 rises
      3'h6: img_pattern = 4'h9;          // 3 falls
      3'h7: img_pattern = 4'hb;          // 2 rises
      default: img_pattern = `CSQ_IMG_REST;
    endcase
  endfunction : img_pattern

  // reverse phase order for a section that transfers the other way
  function automatic logic [3:0] flip4(input logic [3:0] v);
    flip4 = {v[0], v[1], v[2], v[3]};
  endfunction : flip4

  assign last_line = (i_line_count == '0) ? '0 : i_line_count - 1'b1;
  assign last_pix = (i_pixel_count == '0) ? '0 : i_pixel_count - 1'b1;
  assign pix_end = (pc_r == SER - 12'h001);
  assign line_end = (state_r == csq_pkg::CSQ_SER) && pix_end && (pix_r == last_pix);
  assign sum_last = (cfg_r.sum_count == 4'h0) || (sum_r == cfg_r.sum_count - 4'h1);

  // configuration is captured only when idle so routing never changes mid-frame
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r <= '0;
    end else if (state_r == csq_pkg::CSQ_IDLE && i_start) begin
      cfg_r <= i_cfg;
    end
  end

  // main sequence and long-wait timer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= csq_pkg::CSQ_IDLE;
      tmr_r <= '0;
      step_r <= '0;
    end else begin
      if (tmr_r != 12'h000) begin
        tmr_r <= tmr_r - 12'h001;
      end
      case (state_r)
        csq_pkg::CSQ_IDLE: begin
          // clocks stay frozen here until a frame is asked for
          if (i_start) begin
            state_r <= csq_pkg::CSQ_PRE;
            tmr_r <= DRT - 12'h001;
          end
        end
        csq_pkg::CSQ_PRE: begin
          if (tmr_r == 12'h000) begin
            state_r <= csq_pkg::CSQ_IMG;
            step_r <= 3'h1;
            tmr_r <= OI - 12'h001;
          end
        end
        csq_pkg::CSQ_IMG: begin
          if (tmr_r == 12'h000) begin
            step_r <= step_r + 3'h1; // step 7 wraps to rest: last fall
            if (step_r == 3'h7) begin
              state_r <= csq_pkg::CSQ_POST;
              tmr_r <= DTR - 12'h001;
            end else begin
              tmr_r <= OI - 12'h001;
            end
          end
        end
        csq_pkg::CSQ_POST: begin
          if (tmr_r == 12'h000) begin
            if (line_r < i_dump_lines) begin
              state_r <= csq_pkg::CSQ_DHOLD;
              tmr_r <= DUMP - 12'h001;
            end else begin
              state_r <= csq_pkg::CSQ_SER;
            end
          end
        end
        csq_pkg::CSQ_SER: begin
          if (line_end) begin
            state_r <= (line_r == last_line) ? csq_pkg::CSQ_IDLE : csq_pkg::CSQ_PRE;
            tmr_r <= DRT - 12'h001;
          end
        end
        csq_pkg::CSQ_DHOLD: begin
          if (tmr_r == 12'h000) begin
            state_r <= csq_pkg::CSQ_DREST;
            tmr_r <= DUMP - 12'h001;
          end
        end
        csq_pkg::CSQ_DREST: begin
          if (tmr_r == 12'h000) begin
            state_r <= (line_r == last_line) ? csq_pkg::CSQ_IDLE : csq_pkg::CSQ_PRE;
            tmr_r <= DRT - 12'h001;
          end
        end
        default: begin
          state_r <= csq_pkg::CSQ_IDLE;
        end
      endcase
    end
  end

  // line counter: advances when a line is read or dumped
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_r <= '0;
    end else if (state_r == csq_pkg::CSQ_IDLE) begin
      line_r <= '0;
    end else if (line_end || (state_r == csq_pkg::CSQ_DREST && tmr_r == 12'h000)) begin
      line_r <= line_r + 1'b1;
    end
  end

  // serial period and pixel counters run only during readout
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_r <= '0;
      pix_r <= '0;
    end else if (state_r != csq_pkg::CSQ_SER) begin
      pc_r <= '0;
      pix_r <= '0;
    end else if (pix_end) begin
      pc_r <= '0;
      pix_r <= pix_r + 1'b1;
    end else begin
      pc_r <= pc_r + 12'h001;
    end
  end

  // summing counter: counts packets merged in the summing wells
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sum_r <= '0;
    end else if (state_r != csq_pkg::CSQ_SER) begin
      sum_r <= '0;
    end else if (pix_end) begin
      sum_r <= sum_last ? 4'h0 : sum_r + 4'h1;
    end
  end

  // pin composition; serial drives 2/3 stay high outside readout and dumping
  logic ser_on;       // serial clocks running
  logic drv1;         // serial drive 1
  logic drv2;         // serial drive 2
  logic drv3;         // serial drive 3
  logic drv_rst;      // output reset drive
  logic [3:0] img;    // image drives 1..4 in bits 0..3
  logic [3:0] hp2;    // per-half phase 2 after routing
  logic [3:0] hp3;    // per-half phase 3 after routing
  logic [3:0] hsum;   // per-half summing gate
  logic dumping;      // phases 2/3 pulled low for a dump

  assign ser_on = (state_r == csq_pkg::CSQ_SER);
  assign dumping = (state_r == csq_pkg::CSQ_DHOLD) || (state_r == csq_pkg::CSQ_DREST);
  assign img = img_pattern(step_r);
  // three phases with overlapping edges; the trade is a short phase 2 for long sampling
  assign drv_rst = ser_on && (pc_r < WX);
  assign drv2 = ser_on ? (pc_r < T2F) : !dumping;
  assign drv3 = ser_on ? (pc_r >= T2F - OVL && pc_r < T3F) : !dumping;
  assign drv1 = ser_on && (pc_r >= T3F - OVL || pc_r < OVL);

  // per-half routing of serial drives 2 and 3, and summing gate behaviour
  genvar gh;
  generate
    for (gh = 0; gh < 4; gh++) begin : g_half
      // forward uses drives in order, reverse swaps phases 2 and 3
      assign hp2[gh] = cfg_r.reverse[gh] ? drv3 : drv2;
      assign hp3[gh] = cfg_r.reverse[gh] ? drv2 : drv3;
      // held high while packets gather, released as drive 3 on the last
      assign hsum[gh] = cfg_r.sum_enable[gh] ? (!ser_on || !sum_last || drv3) :
                        hp3[gh];
    end
  endgenerate

  // image and transfer gate routing by readout mode
  always_comb begin
    pins_nxt = '0;
    case (cfg_r.mode)
      csq_pkg::CSQ_FULL_LOWER: begin
        pins_nxt.upper_image_phase = flip4(img);
        pins_nxt.upper_transfer_gate = 1'b0;
        pins_nxt.lower_image_phase = img;
        pins_nxt.lower_transfer_gate = img[0];
      end
      csq_pkg::CSQ_FULL_UPPER: begin
        pins_nxt.upper_image_phase = img;
        pins_nxt.upper_transfer_gate = img[3];
        pins_nxt.lower_image_phase = flip4(img);
        pins_nxt.lower_transfer_gate = 1'b0;
      end
      default: begin
        pins_nxt.upper_image_phase = img;
        pins_nxt.upper_transfer_gate = img[3];
        pins_nxt.lower_image_phase = img;
        pins_nxt.lower_transfer_gate = img[0];
      end
    endcase
    pins_nxt.upper_register_phase_1 = drv1;
    pins_nxt.lower_register_phase_1 = drv1;
    pins_nxt.upper_left_phase_2 = hp2[0];
    pins_nxt.upper_left_phase_3 = hp3[0];
    pins_nxt.upper_right_phase_2 = hp2[1];
    pins_nxt.upper_right_phase_3 = hp3[1];
    pins_nxt.lower_left_phase_2 = hp2[2];
    pins_nxt.lower_left_phase_3 = hp3[2];
    pins_nxt.lower_right_phase_2 = hp2[3];
    pins_nxt.lower_right_phase_3 = hp3[3];
    pins_nxt.upper_left_summing_gate = hsum[0];
    pins_nxt.upper_right_summing_gate = hsum[1];
    pins_nxt.lower_left_summing_gate = hsum[2];
    pins_nxt.lower_right_summing_gate = hsum[3];
    pins_nxt.output_reset = {4{drv_rst}};
    // dump gate leaves its rest level only while a line is discarded
    pins_nxt.charge_dump_gate = {2{state_r == csq_pkg::CSQ_DHOLD}};
  end

  // registered outputs so pin edges are glitch free
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pins <= '0;
      o_busy <= 1'b0;
      o_pixel_valid <= 1'b0;
      o_frame_done <= 1'b0;
    end else begin
      o_pins <= pins_nxt;
      o_busy <= (state_r != csq_pkg::CSQ_IDLE);
      o_pixel_valid <= ser_on && pix_end && sum_last;
      o_frame_done <= (state_r != csq_pkg::CSQ_IDLE) && (line_r == last_line)
                      && (line_end || (state_r == csq_pkg::CSQ_DREST && tmr_r == 12'h000));
    end
  end

  // helper: cycles spent waiting before the first image edge, and dump gap
  logic [11:0] pre_cnt_r; // cycles in the pre-transfer wait
  logic [11:0] dgap_r;    // cycles since phase 2 fell with the dump gate up
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt_r <= '0;
      dgap_r <= '0;
    end else begin
      pre_cnt_r <= (state_r == csq_pkg::CSQ_PRE) ? pre_cnt_r + 12'h001 : 12'h000;
      dgap_r <= (o_pins.charge_dump_gate[0] && !o_pins.upper_left_phase_2) ?
                dgap_r + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_static_idle: assert property (
    // the first edge after reset loads the rest pattern, so it is left out
    (state_r == csq_pkg::CSQ_IDLE) && $past(state_r == csq_pkg::CSQ_IDLE) && $past(i_rst_b)
      |=> $stable(o_pins))
    else $error("pins moved while collecting charge");
  chk_phase2_hold: assert property (
    (state_r inside {csq_pkg::CSQ_PRE, csq_pkg::CSQ_IMG, csq_pkg::CSQ_POST}) |=>
      o_pins.upper_left_phase_2 && o_pins.upper_right_phase_2 &&
      o_pins.lower_left_phase_2 && o_pins.lower_right_phase_2 &&
      o_pins.upper_left_phase_3 && o_pins.lower_right_phase_3)
    else $error("serial phase 2 or 3 low during line transfer");
  chk_upper_gate_low: assert property (
    o_busy && cfg_r.mode == csq_pkg::CSQ_FULL_LOWER |-> !o_pins.upper_transfer_gate)
    else $error("upper transfer gate not held low in full lower mode");
  chk_lower_gate_low: assert property (
    o_busy && cfg_r.mode == csq_pkg::CSQ_FULL_UPPER |-> !o_pins.lower_transfer_gate)
    else $error("lower transfer gate not held low in full upper mode");
  chk_split_gates: assert property (
    o_busy && $past(o_busy) && cfg_r.mode == csq_pkg::CSQ_SPLIT |->
      o_pins.upper_transfer_gate == o_pins.upper_image_phase[3] &&
      o_pins.lower_transfer_gate == o_pins.lower_image_phase[0])
    else $error("split transfer gates do not follow their image drives");
  chk_pre_delay: assert property (
    (state_r == csq_pkg::CSQ_PRE) && (tmr_r == 12'h000) |-> pre_cnt_r == DRT - 12'h001)
    else $error("serial stop to image rise wait has the wrong length");
  chk_reset_width: assert property (
    $rose(o_pins.output_reset[0]) |-> o_pins.output_reset[0] [*7] ##1 !o_pins.output_reset[0])
    else $error("output reset pulse width wrong");
  chk_phase2_after: assert property (
    $fell(o_pins.output_reset[0]) && !cfg_r.reverse[0] |->
      o_pins.upper_left_phase_2 [*4] ##1 !o_pins.upper_left_phase_2)
    else $error("phase 2 fall not four cycles after reset");
  chk_dump_fall: assert property (
    $fell(o_pins.charge_dump_gate[0]) |-> $past(dgap_r) == DUMP - 12'h001)
    else $error("dump gate fell at the wrong time after phases 2 and 3");
  chk_sum_plain: assert property (
    !$past(cfg_r.sum_enable[1]) |-> o_pins.upper_right_summing_gate == o_pins.upper_right_phase_3)
    else $error("unused summing gate differs from its phase 3");

  cov_dump_line: cover property ($fell(o_pins.charge_dump_gate[1]));
  cov_full_lower: cover property (o_frame_done && cfg_r.mode == csq_pkg::CSQ_FULL_LOWER);
  cov_sum_release: cover property (cfg_r.sum_enable[0] && $fell(o_pins.upper_left_summing_gate));
  cov_reverse: cover property (o_pixel_valid && cfg_r.reverse[3]);

endmodule : csq_sequencer

// ==== csq_sequencer_test.sv ====
// csq_sequencer_test.sv: frame-level scenarios for the sensor clock sequencer.
// assumes the sensor model on the pins; the design carries its own assertions.
`timescale 1ns/1ps
module csq_sequencer_test;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_start = 1'b0;
  csq_pkg::csq_cfg_s i_cfg = '0;
  logic [12:0] i_line_count = 13'h0001;
  logic [12:0] i_dump_lines = 13'h0000;
  logic [12:0] i_pixel_count = 13'h0001;
  csq_pkg::csq_pins_s o_pins;
  csq_pkg::csq_pins_s p, q; // this and last pin sample
  logic o_busy, o_pixel_valid, o_frame_done, o_fault, rbad, hbad;
  logic [15:0] falls, f0;
  logic [3:0] drv, pd, o;
  int bad_count = 0;
  int cmp_count = 0;
  int t, e1, e8, ts, trr, rw, trf, dx, nv, tv, per, tpf, tdf, da, db, sgl, p3l;
  always #4 i_clk = ~i_clk; // 125 MHz
  csq_sequencer csq_sequencer_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
    .i_cfg(i_cfg), .i_line_count(i_line_count), .i_dump_lines(i_dump_lines),
    .i_pixel_count(i_pixel_count), .o_pins(o_pins), .o_busy(o_busy),
    .o_pixel_valid(o_pixel_valid), .o_frame_done(o_frame_done));
  csq_sensor_model csq_sensor_model_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pins(o_pins),
    .o_gate_falls(falls), .o_fault(o_fault));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      $display("Error at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      bad_count++;
    end
  endtask : check
  // run one frame, sampling pins each falling edge; a second start is sent while busy
  task automatic frame(input csq_pkg::csq_cfg_s c, input int lines, input int dump, input int pix);
    @(negedge i_clk);
    i_cfg = c;
    i_line_count = lines[12:0];
    i_dump_lines = dump[12:0];
    i_pixel_count = pix[12:0];
    i_start = 1'b1;
    {t, e1, e8, ts, trr, rw, trf, dx, nv, tv, per, tpf, tdf, da, db, sgl, p3l} = '0;
    {rbad, hbad} = 2'b00;
    q = o_pins;
    pd = 4'h3;
    while (o_frame_done !== 1'b1 && t < 40000) begin
      @(negedge i_clk);
      t++;
      i_start = (t == 100); // must be ignored
      p = o_pins;
      if (t == 3) f0 = falls; // a mode change may first drop an idle transfer gate
      if (t == 2) check(o_busy, 1, "busy");
      drv = (c.mode == csq_pkg::CSQ_FULL_UPPER) ? p.upper_image_phase : p.lower_image_phase;
      o = (c.mode == csq_pkg::CSQ_FULL_UPPER) ? p.lower_image_phase : p.upper_image_phase;
      // routing settles a cycle or two after the mode is latched
      if (t > 2 && o !== ((c.mode == csq_pkg::CSQ_SPLIT) ? drv : {drv[0], drv[1], drv[2], drv[3]}))
        rbad = 1;
      if (t > 2 && p.upper_transfer_gate !== ((c.mode == csq_pkg::CSQ_FULL_LOWER) ? 1'b0 : drv[3]))
        rbad = 1;
      if (t > 2 && p.lower_transfer_gate !== ((c.mode == csq_pkg::CSQ_FULL_UPPER) ? 1'b0 : drv[0]))
        rbad = 1;
      if (c.reverse[1] && {p.upper_right_phase_2, p.upper_right_phase_3} !==
          {p.upper_left_phase_3, p.upper_left_phase_2}) rbad = 1;
      if (c.sum_enable == 4'h0 && {p.upper_left_summing_gate, p.upper_right_summing_gate,
          p.lower_left_summing_gate, p.lower_right_summing_gate} !== {p.upper_left_phase_3,
          p.upper_right_phase_3, p.lower_left_phase_3, p.lower_right_phase_3}) hbad = 1;
      if (dump == 0 && p.charge_dump_gate !== 2'b00) hbad = 1;
      if (t > 2 && drv !== pd && ts == 0) begin
        if (e1 == 0) e1 = t;
        e8 = t;
      end
      pd = drv;
      if (p.output_reset[0] && !q.output_reset[0]) trr = t;
      if (!p.output_reset[0] && q.output_reset[0] && rw == 0) begin
        rw = t - trr;
        trf = t;
      end
      if (!p.upper_left_phase_2 && q.upper_left_phase_2) begin
        if (ts == 0) ts = t;
        if (trf != 0 && dx == 0) dx = t - trf;
        tpf = t;
      end
      if (!p.charge_dump_gate[0] && q.charge_dump_gate[0]) begin
        da = t - tpf;
        tdf = t;
      end
      if (p.upper_left_phase_2 && !q.upper_left_phase_2 && tdf != 0 && db == 0) db = t - tdf;
      if (o_pixel_valid === 1'b1) begin
        nv++;
        per = t - tv;
        tv = t;
      end
      sgl += (p.upper_left_summing_gate === 1'b0);
      p3l += (p.upper_left_phase_3 === 1'b0);
      q = p;
    end
    check(t < 40000, 1, "frame end");
    check(o_fault, 0, "image moved with phase 2 low");
    repeat (5) @(negedge i_clk);
    check(o_busy, 0, "start while busy");
  endtask : frame
  task automatic test_rest;
    repeat (2) @(negedge i_clk);
    q = o_pins;
    check({q.upper_image_phase, q.lower_image_phase}, 8'h33, "rest drives");
    check({q.upper_transfer_gate, q.lower_transfer_gate}, 2'h1, "rest gates");
    check(q.charge_dump_gate, 2'h0, "dump gate rest");
    repeat (50) @(negedge i_clk);
    check(o_pins === q, 1, "static while collecting");
  endtask : test_rest
  task automatic test_split;
    frame('{csq_pkg::CSQ_SPLIT, 4'ha, 4'h0, 4'h0}, 1, 0, 3);
    check(rbad, 0, "split routing");
    check(hbad, 0, "summing or dump gate");
    check(e8 - e1, 8750, "edge span");
    check(e1 >= 250, 1, "serial stop to image");
    check(ts - e8 >= 1000, 1, "image to serial");
    check(ts >= 11250 && ts <= 12500, 1, "line transfer");
    check(nv, 3, "packets");
    check(per, 125, "serial period");
    check(rw, 7, "reset width");
    check(dx, 4, "reset to phase 2");
    check(falls - f0, 2, "lines moved");
  endtask : test_split
  task automatic test_full;
    for (int m = 1; m < 3; m++) begin
      frame('{csq_pkg::csq_mode_e'(m), 4'h0, 4'h0, 4'h0}, 1, 0, 1);
      check(rbad, 0, "full frame routing");
      check(falls - f0, 1, "lines moved");
    end
  endtask : test_full
  task automatic test_dump;
    frame('{csq_pkg::CSQ_SPLIT, 4'h0, 4'h0, 4'h0}, 2, 1, 1);
    check(da, 2500, "phase fall to dump fall");
    check(db, 2500, "dump fall to phase rise");
    check(nv, 1, "dumped line not read");
    check(falls - f0, 4, "lines moved");
  endtask : test_dump
  task automatic test_sum;
    frame('{csq_pkg::CSQ_SPLIT, 4'h0, 4'h1, 4'h2}, 1, 0, 4);
    check(nv, 2, "summed packets");
    check(sgl * 2, p3l, "summing gate release");
  endtask : test_sum
  initial begin
    #800000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst_b = 1'b1;
    test_rest;
    test_split;
    test_full;
    test_dump;
    test_sum;
    finish_test;
  end
endmodule : csq_sequencer_test
